// [rtl/rhsf_link_if.sv]
// Carrier between the serial-clock shifter and the core controller
`timescale 1ns/100ps
`default_nettype none

interface rhsf_link_if;
   import rhsf_pkg::*;

   logic [WORD_BITS-1:0]  word;
   logic [PHASE_BITS-1:0] phase;
   logic                  full;
   logic [WORD_BITS-1:0]  reply;

   modport link
   (
      output word,
      output phase,
      output full,
      input  reply
   );

   modport core
   (
      input  word,
      input  phase,
      input  full,
      output reply
   );
endinterface : rhsf_link_if

`default_nettype wire

// [rtl/rhsf_link_shifter.sv]
// Serial-clock domain: input shift register, bit counter, open-drain output
`timescale 1ns/100ps
`default_nettype none

module rhsf_link_shifter
   import rhsf_pkg::*;
(
   // Serial pins
   input  wire logic serial_clk_in,
   input  wire logic frame_sel_n_in,
   input  wire logic serial_data_in,
   output logic      serial_readback_out,
   output logic      serial_readback_oe_out,
   // Core side
   rhsf_link_if.link link
);
   typedef struct packed {
      logic [WORD_BITS-1:0]  word;
      logic [PHASE_BITS-1:0] phase;
      logic                  full;
   } rhsf_shift_type;

   rhsf_shift_type st;
   rhsf_shift_type next_st;
   logic           armed;

   // Frame select high clears the first-bit marker; the clock may stand still
   always_ff @(negedge serial_clk_in or posedge frame_sel_n_in)
   begin
      if (frame_sel_n_in)
      begin
         armed <= 1'b0;
      end
      else
      begin
         armed <= 1'b1;
      end
   end

   always_comb
   begin
      next_st = st;
      if (!frame_sel_n_in)
      begin
         if (!armed)
         begin
            next_st.word  = {link.reply[WORD_BITS-2:0], serial_data_in};
            next_st.phase = PHASE_FIRST;
            next_st.full  = 1'b0;
         end
         else
         begin
            next_st.word  = {st.word[WORD_BITS-2:0], serial_data_in};
            next_st.phase = st.phase + PHASE_FIRST;
            if (st.phase == PHASE_LAST)
            begin
               next_st.full = 1'b1;
            end
         end
      end
   end

   always_ff @(negedge serial_clk_in)
   begin
      st <= next_st;
   end

   assign link.word  = st.word;
   assign link.phase = st.phase;
   assign link.full  = st.full;

   assign serial_readback_out    = 1'b0;
   assign serial_readback_oe_out = !frame_sel_n_in && armed && !st.word[WORD_BITS-1];
endmodule : rhsf_link_shifter

`default_nettype wire

// [rtl/rhsf_pkg.sv]
// Shared constants and types of the rheostat serial front end
package rhsf_pkg;

   // Serial word layout
   localparam int WORD_BITS    = 16;
   localparam int WIPER_BITS   = 10;
   localparam int CMD_BITS     = 4;
   localparam int CMD_LSB      = 10;
   localparam int PHASE_BITS   = 4;
   localparam logic [PHASE_BITS-1:0] PHASE_FIRST = 4'h1;
   localparam logic [PHASE_BITS-1:0] PHASE_LAST  = 4'hf;
   localparam logic [PHASE_BITS-1:0] PHASE_WHOLE = 4'h0;

   // Wiper and nonvolatile store
   localparam logic [WIPER_BITS-1:0] WIPER_RESET = 10'h200;
   localparam int NV_LOCS      = 50;
   localparam int NV_ADDR_BITS = 6;
   localparam logic [NV_ADDR_BITS-1:0] NV_NONE = 6'h00;
   localparam logic [NV_ADDR_BITS-1:0] NV_LAST = 6'h32;

   // Control register bits
   localparam int CTRL_BITS      = 3;
   localparam int CTRL_NV_EN     = 0;
   localparam int CTRL_WIPER_EN  = 1;
   localparam int CTRL_DONE      = 2;
   localparam int SHUTDOWN_BIT   = 0;

   // Store lock time
   localparam int CORE_CLK_KHZ      = 200000;
   localparam int NV_PROGRAM_MS     = 350;
   localparam int NV_PROGRAM_CYCLES = NV_PROGRAM_MS * CORE_CLK_KHZ;
   localparam int LOCK_CNT_BITS     = 27;

   typedef enum logic [CMD_BITS-1:0] {
      CMD_NOP          = 4'h0,
      CMD_WRITE_WIPER  = 4'h1,
      CMD_READ_WIPER   = 4'h2,
      CMD_STORE_NV     = 4'h3,
      CMD_SOFT_RESET   = 4'h4,
      CMD_READ_NV      = 4'h5,
      CMD_READ_NV_ADDR = 4'h6,
      CMD_WRITE_CTRL   = 4'h7,
      CMD_READ_CTRL    = 4'h8,
      CMD_SHUTDOWN     = 4'h9
   } rhsf_cmd_type;

endpackage : rhsf_pkg

// [rtl/rhsf_rheostat_serial_frontend.sv]
// Rheostat serial front end: frame decode, wiper, control and nonvolatile store
//
// Functional notes
// - Serial data is sampled into the shift register on serial clock falls.
// - Host pulls frame select low; shifting happens only while it stays low.
// - Decoded register updates when frame select rises after sixteen clocks.
// - Frame select rising early aborts the frame; nothing changes.
// - Serial output is open drain: pulls low or releases only.
// - Serial output shifts register contents for daisy chains or readback data.
// - Input register is sixteen bits, loaded in step with serial clock.
// - Wiper output follows the volatile wiper register directly.
// - Volatile wiper register may be rewritten without limit.
// - Last stored wiper value is restored at every power-up.
// - Nonvolatile store locks out state changes for about 350 ms.
// - Wiper, control enables and shutdown are writable through the serial interface; done is not.
// - Word is two zero bits, four command bits, ten data bits, MSB first.
// - Bits counted in sixteens; other frame lengths are not processed.
// - Wiper and store writes stay blocked until enabled via control register.
// - Wiper read returns data during the last ten clocks of the next frame.
`timescale 1ns/100ps
`default_nettype none

module rhsf_rheostat_serial_frontend
   import rhsf_pkg::*;
#(
   parameter int LOCK_CYCLES = NV_PROGRAM_CYCLES
)
(
   // Core clock and reset
   input  wire logic                  core_clk_in,
   input  wire logic                  rst_in,
   // Serial link
   input  wire logic                  serial_clk_in,
   input  wire logic                  frame_sel_n_in,
   input  wire logic                  serial_data_in,
   output logic                       serial_readback_out,
   output logic                       serial_readback_oe_out,
   // Wiper and status
   output logic [WIPER_BITS-1:0]      wiper_position_out,
   output logic                       shutdown_out,
   output logic                       nv_busy_out
);
   if (LOCK_CYCLES < 2 || LOCK_CYCLES >= (1 << LOCK_CNT_BITS))
   begin : g_bad_lock
      $error("LOCK_CYCLES out of range");
   end

   typedef enum logic [1:0] {
      ST_RESTORE,
      ST_READY,
      ST_LOCKED
   } rhsf_state_type;

   typedef struct packed {
      rhsf_state_type             state;
      logic                       sel_prev;
      logic [WIPER_BITS-1:0]      wiper;
      logic                       nv_en;
      logic                       wiper_en;
      logic                       done;
      logic                       shutdown;
      logic [WORD_BITS-1:0]       reply;
      logic [LOCK_CNT_BITS-1:0]   lock_cnt;
   } rhsf_core_type;

   rhsf_core_type st;
   rhsf_core_type next_st;

   rhsf_link_if link_bus ();

   logic                       sel_sync;
   logic                       frame_end;
   logic                       word_ok;
   logic                       locked;
   logic                       nv_wr;
   rhsf_cmd_type               cmd;
   logic [WIPER_BITS-1:0]      data;
   logic [NV_ADDR_BITS-1:0]    nv_loc;
   logic [WIPER_BITS-1:0]      restore_val;
   logic [WIPER_BITS-1:0]      nv_read_val;
   logic [CTRL_BITS-1:0]       ctrl_view;

   // Nonvolatile array: deliberately outside the reset so it survives rst_in
   logic [WIPER_BITS-1:0]      nv_mem [1:NV_LOCS];
   logic [NV_ADDR_BITS-1:0]    nv_used = NV_NONE;

   rhsf_link_shifter u_shifter
   (
      .serial_clk_in          (serial_clk_in),
      .frame_sel_n_in         (frame_sel_n_in),
      .serial_data_in         (serial_data_in),
      .serial_readback_out    (serial_readback_out),
      .serial_readback_oe_out (serial_readback_oe_out),
      .link                   (link_bus.link)
   );

   rhsf_sync2 #(.RESET_LEVEL(1'b1)) u_sel_sync
   (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .async_in    (frame_sel_n_in),
      .sync_out    (sel_sync)
   );

   // Word and phase are quasi-static once frame select is seen high
   assign frame_end = sel_sync && !st.sel_prev;
   assign word_ok   = link_bus.full && (link_bus.phase == PHASE_WHOLE);
   // command then data, leading bits ignored
   assign cmd       = rhsf_cmd_type'(link_bus.word[CMD_LSB +: CMD_BITS]);
   assign data      = link_bus.word[WIPER_BITS-1:0];
   assign nv_loc    = data[NV_ADDR_BITS-1:0];
   assign locked    = (st.state == ST_LOCKED);
   assign ctrl_view = {st.done, st.wiper_en, st.nv_en};

   assign restore_val = (nv_used != NV_NONE) ? nv_mem[nv_used] : WIPER_RESET;
   assign nv_read_val = (nv_loc != NV_NONE && nv_loc <= NV_LAST) ? nv_mem[nv_loc] : '0;

   always_comb
   begin
      next_st          = st;
      nv_wr            = 1'b0;
      next_st.sel_prev = sel_sync;
      unique case (st.state)
         ST_RESTORE:
         begin
            next_st.wiper = restore_val;
            next_st.state = ST_READY;
         end
         ST_READY:
         begin
            next_st.state = ST_READY;
         end
         ST_LOCKED:
         begin
            if (st.lock_cnt == '0)
            begin
               next_st.state = ST_READY;
               next_st.done  = 1'b1;
            end
            else
            begin
               next_st.lock_cnt = st.lock_cnt - 1'b1;
            end
         end
         default:
         begin
            // Illegal code recovers through a fresh restore
            next_st.state = ST_RESTORE;
         end
      endcase
      if (frame_end && word_ok && st.state != ST_RESTORE)
      begin
         next_st.reply = '0;
         case (cmd)
            CMD_WRITE_WIPER:
            begin
               if (!locked && st.wiper_en)
               begin
                  next_st.wiper = data;
               end
            end
            CMD_READ_WIPER:
            begin
               next_st.reply = WORD_BITS'(st.wiper);
            end
            CMD_STORE_NV:
            begin
               if (!locked && st.nv_en && nv_used < NV_LAST)
               begin
                  nv_wr            = 1'b1;
                  next_st.state    = ST_LOCKED;
                  next_st.lock_cnt = LOCK_CNT_BITS'(LOCK_CYCLES - 1);
                  next_st.done     = 1'b0;
               end
            end
            CMD_SOFT_RESET:
            begin
               if (!locked)
               begin
                  next_st.wiper = restore_val;
               end
            end
            CMD_READ_NV:
            begin
               next_st.reply = WORD_BITS'(nv_read_val);
            end
            CMD_READ_NV_ADDR:
            begin
               next_st.reply = WORD_BITS'(nv_used);
            end
            CMD_WRITE_CTRL:
            begin
               if (!locked)
               begin
                  next_st.nv_en    = data[CTRL_NV_EN];
                  next_st.wiper_en = data[CTRL_WIPER_EN];
               end
            end
            CMD_READ_CTRL:
            begin
               next_st.reply = WORD_BITS'(ctrl_view);
            end
            CMD_SHUTDOWN:
            begin
               if (!locked)
               begin
                  next_st.shutdown = data[SHUTDOWN_BIT];
               end
            end
            default:
            begin
               next_st.reply = '0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         st.state    <= ST_RESTORE;
         st.sel_prev <= 1'b1;
         st.wiper    <= WIPER_RESET;
         st.nv_en    <= 1'b0;
         st.wiper_en <= 1'b0;
         st.done     <= 1'b0;
         st.shutdown <= 1'b0;
         st.reply    <= '0;
         st.lock_cnt <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Store appends; a full array refuses further stores
   always_ff @(posedge core_clk_in)
   begin
      if (nv_wr)
      begin
         nv_mem[nv_used + 1'b1] <= st.wiper;
         nv_used                <= nv_used + 1'b1;
      end
   end

   assign link_bus.reply = st.reply;
   assign wiper_position_out = st.wiper;
   assign shutdown_out       = st.shutdown;
   assign nv_busy_out        = locked;

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_good_frame;
      frame_end && word_ok && st.state != ST_RESTORE;
   endsequence

   sequence s_wiper_write;
      s_good_frame ##0 (cmd == CMD_WRITE_WIPER) && st.wiper_en && !locked;
   endsequence

   AST_WIPER_WRITE: assert property (s_wiper_write |=> wiper_position_out == $past(data))
      else $error("wiper write not applied");

   AST_ABORT_KEEPS: assert property (frame_end && !word_ok && st.state == ST_READY |=>
      $stable(wiper_position_out) && $stable(ctrl_view) && $stable(st.reply) && !nv_busy_out)
      else $error("aborted frame changed state");

   AST_PROTECTED: assert property (s_good_frame ##0 (cmd == CMD_WRITE_WIPER) && !st.wiper_en
      |=> $stable(wiper_position_out))
      else $error("protected wiper changed");

   AST_LOCK_START: assert property (s_good_frame ##0 nv_wr |=> nv_busy_out [*2] ##0 !st.done)
      else $error("store did not lock");

   AST_LOCK_IGNORE: assert property (locked && frame_end |=> $stable(wiper_position_out)
      && $stable(shutdown_out) && $stable(st.wiper_en) && $stable(st.nv_en))
      else $error("locked device changed");

   AST_LOCK_END: assert property ($fell(nv_busy_out) |-> st.done && $past(st.lock_cnt) == '0)
      else $error("lock ended early or without done");

   AST_STORE_COUNT: assert property (nv_wr |=> nv_used == $past(nv_used) + 1'b1)
      else $error("store address not advanced");

   AST_READ_REPLY: assert property (s_good_frame ##0 cmd == CMD_READ_WIPER
      |=> st.reply == WORD_BITS'($past(st.wiper)))
      else $error("wiper readback word wrong");

   AST_RELEASE_IDLE: assert property (frame_sel_n_in |-> !serial_readback_oe_out)
      else $error("output driven outside frame");

   AST_OPEN_DRAIN: assert property (serial_readback_oe_out |-> !serial_readback_out)
      else $error("output driven high");
endmodule : rhsf_rheostat_serial_frontend

`default_nettype wire

// [rtl/rhsf_sync2.sv]
// Two-stage level synchroniser into the core clock
`timescale 1ns/100ps
`default_nettype none

module rhsf_sync2
#(
   parameter logic RESET_LEVEL = 1'b1
)
(
   // Clock and reset
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   // Level
   input  wire logic async_in,
   output logic      sync_out
);
   typedef struct packed {
      logic meta;
      logic stable;
   } rhsf_sync_type;

   rhsf_sync_type st;
   rhsf_sync_type next_st;

   always_comb
   begin
      next_st.meta   = async_in;
      next_st.stable = st.meta;
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         st <= {RESET_LEVEL, RESET_LEVEL};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign sync_out = st.stable;
endmodule : rhsf_sync2

`default_nettype wire

// [testbench/rhsf_host_model.sv]
// Behavioural serial host that drives frames into the front end
`timescale 1ns/100ps
`default_nettype none

module rhsf_host_model
(
   // Serial pins toward the device
   output logic      serial_clk_out,
   output logic      frame_sel_n_out,
   output logic      serial_data_out,
   // Resolved open-drain line
   input  wire logic readback_in
);
   localparam realtime HALF = 32.0;

   initial
   begin
      serial_clk_out  = 1'b0;
      frame_sel_n_out = 1'b1;
      serial_data_out = 1'b0;
   end

   // Sends the low nbits of data; rx keeps the last 16 line samples
   task automatic xfer(input logic [31:0] data, input int nbits, output logic [15:0] rx);
      rx = 16'hffff;
      frame_sel_n_out = 1'b0;
      #20.3;
      for (int i = nbits - 1; i >= 0; i--)
      begin
         // Sampled just before the rise, long after the prior fall
         rx = {rx[14:0], readback_in};
         serial_data_out = data[i];
         serial_clk_out  = 1'b1;
         #HALF;
         serial_clk_out = 1'b0;
         #HALF;
      end
      #3.1;
      frame_sel_n_out = 1'b1;
      // clock stands still, data no longer valid
      serial_data_out = ~serial_data_out;
      // Gap above the minimum high time
      #517.7;
   endtask : xfer
endmodule : rhsf_host_model

`default_nettype wire

// [testbench/rhsf_rheostat_serial_frontend_tb_top.sv]
// Self-checking bench of the rheostat serial front end
`timescale 1ns/100ps
`default_nettype none

module rhsf_rheostat_serial_frontend_tb_top;
   import rhsf_pkg::*;

   // Short lock keeps the run brief
   localparam int LOCK_LEN = 2000;

   logic                  core_clk_in;
   logic                  rst_in;
   logic                  sclk;
   logic                  fsel_n;
   logic                  sdata;
   logic                  rb_out;
   logic                  rb_oe;
   logic [WIPER_BITS-1:0] wiper;
   logic                  shut;
   logic                  busy;
   int                    errors;
   int                    total_checks;
   logic [15:0]           rx;
   logic [15:0]           u;
   logic [9:0]            v;
   logic [9:0]            nw;
   int                    n;
   wire logic             rb_line = rb_oe ? rb_out : 1'b1;

   rhsf_rheostat_serial_frontend #(.LOCK_CYCLES(LOCK_LEN)) dut
   (
      .core_clk_in            (core_clk_in),
      .rst_in                 (rst_in),
      .serial_clk_in          (sclk),
      .frame_sel_n_in         (fsel_n),
      .serial_data_in         (sdata),
      .serial_readback_out    (rb_out),
      .serial_readback_oe_out (rb_oe),
      .wiper_position_out     (wiper),
      .shutdown_out           (shut),
      .nv_busy_out            (busy)
   );

   rhsf_host_model host
   (
      .serial_clk_out  (sclk),
      .frame_sel_n_out (fsel_n),
      .serial_data_out (sdata),
      .readback_in     (rb_line)
   );

   initial
   begin
      core_clk_in = 1'b0;
      forever #2.5 core_clk_in = ~core_clk_in;
   end

   function automatic logic [15:0] mk(input rhsf_cmd_type c, input logic [9:0] d);
      return {2'b00, c, d};
   endfunction : mk

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   task automatic chk_state(input logic [9:0] ew, input logic es, input logic eb);
      @(negedge core_clk_in);
      total_checks++;
      if ({wiper, shut, busy} !== {ew, es, eb})
      begin
         errors++;
         $display("MISMATCH t=%0t state %h/%b/%b exp %h/%b/%b", $time, wiper, shut, busy, ew, es, eb);
      end
   endtask : chk_state

   task automatic chk_reply(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t line word %h exp %h", $time, got, exp);
      end
   endtask : chk_reply

   task automatic send(input logic [15:0] w);
      logic [15:0] dummy;
      host.xfer({16'h0000, w}, 16, dummy);
   endtask : send

   // Read command, then a blank frame; line is released before the first fall
   task automatic rd(input rhsf_cmd_type c, input logic [9:0] d, input logic [15:0] exp);
      logic [15:0] got;
      send(mk(c, d));
      host.xfer(32'h0, 16, got);
      chk_reply(got, {1'b1, exp[14:0]});
   endtask : rd

   task automatic pulse_reset;
      @(negedge core_clk_in);
      rst_in = 1'b1;
      repeat (20) @(negedge core_clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge core_clk_in);
   endtask : pulse_reset

   initial
   begin
      #400000;
      errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      give_verdict();
   end

   initial
   begin
      errors       = 0;
      total_checks = 0;
      void'($urandom(13));
      rst_in = 1'b1;
      repeat (20) @(negedge core_clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge core_clk_in);
      chk_state(WIPER_RESET, 1'b0, 1'b0);
      send(mk(CMD_WRITE_WIPER, 10'h155));
      chk_state(WIPER_RESET, 1'b0, 1'b0);
      $display("test protect done");

      send(mk(CMD_WRITE_CTRL, 10'h003));
      for (int i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($urandom);
         send(mk(CMD_WRITE_WIPER, v));
         chk_state(v, 1'b0, 1'b0);
         rd(CMD_READ_WIPER, 10'h000, {6'h00, v});
      end
      $display("test wiper done");

      host.xfer({16'h0000, mk(CMD_WRITE_WIPER, ~v) >> 8}, 8, rx);
      chk_state(v, 1'b0, 1'b0);
      host.xfer({15'h0000, mk(CMD_WRITE_WIPER, ~v), 1'b1}, 17, rx);
      chk_state(v, 1'b0, 1'b0);
      u  = 16'($urandom);
      nw = 10'($urandom) | 10'h001;
      host.xfer({u, mk(CMD_WRITE_WIPER, nw)}, 32, rx);
      chk_state(nw, 1'b0, 1'b0);
      chk_reply(rx, u);
      $display("test framing done");

      send(mk(CMD_STORE_NV, 10'h000));
      chk_state(nw, 1'b0, 1'b1);
      send(mk(CMD_WRITE_WIPER, ~nw));
      send(mk(CMD_SHUTDOWN, 10'h001));
      for (n = 0; n < LOCK_LEN + 100 && busy !== 1'b0; n++)
         @(negedge core_clk_in);
      chk_state(nw, 1'b0, 1'b0);
      rd(CMD_READ_CTRL, 10'h000, 16'h0007);
      rd(CMD_READ_NV_ADDR, 10'h000, 16'h0001);
      rd(CMD_READ_NV, 10'h001, {6'h00, nw});
      send(mk(CMD_WRITE_WIPER, v));
      chk_state(v, 1'b0, 1'b0);
      send(mk(CMD_SOFT_RESET, 10'h000));
      chk_state(nw, 1'b0, 1'b0);
      send(mk(CMD_SHUTDOWN, 10'h001));
      chk_state(nw, 1'b1, 1'b0);
      send(mk(CMD_SHUTDOWN, 10'h000));
      chk_state(nw, 1'b0, 1'b0);
      send(mk(CMD_READ_WIPER, 10'h000));
      rd(rhsf_cmd_type'(4'hc), 10'h3ff, 16'h0000);
      chk_state(nw, 1'b0, 1'b0);
      $display("test store done");

      pulse_reset();
      chk_state(nw, 1'b0, 1'b0);
      send(mk(CMD_WRITE_WIPER, v));
      chk_state(nw, 1'b0, 1'b0);
      send(mk(CMD_STORE_NV, 10'h000));
      chk_state(nw, 1'b0, 1'b0);
      rd(CMD_READ_NV_ADDR, 10'h000, 16'h0001);
      $display("test restore done");
      give_verdict();
   end
endmodule : rhsf_rheostat_serial_frontend_tb_top

`default_nettype wire
